// >>> src/fws_consts.svh
// Constants of the flash write-status controller: offsets, fields, commands, timing.
// Assumes a 250 MHz clock and a byte-mode flash with an 8-bit data bus.
`ifndef FWS_CONSTS_SVH
`define FWS_CONSTS_SVH
`define FWS_CLK_PERIOD_NS  4
`define FWS_T_STROBE_NS    70
`define FWS_T_RECOV_NS     20
`define FWS_STROBE_CYC     ((`FWS_T_STROBE_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_RECOV_CYC      ((`FWS_T_RECOV_NS + `FWS_CLK_PERIOD_NS - 1) / `FWS_CLK_PERIOD_NS)
`define FWS_CNT_W          5
`define FWS_ADDR_W         20
`define FWS_REG_CTRL       5'h00
`define FWS_REG_ADDR       5'h04
`define FWS_REG_DATA       5'h08
`define FWS_REG_STATUS     5'h0c
`define FWS_CTRL_GO        0
`define FWS_CTRL_OP_LSB    1
`define FWS_ST_BUSY        0
`define FWS_ST_DONE        1
`define FWS_ST_FAIL        2
`define FWS_ST_VERIFY      3
`define FWS_ST_RDY         4
`define FWS_ST_RESULT_LSB  8
`define FWS_ST_LAST_LSB    16
`define FWS_OP_PROG        2'h0
`define FWS_OP_CHIP        2'h1
`define FWS_OP_SECT        2'h2
`define FWS_OP_RESET       2'h3
`define FWS_UNLOCK_A1      20'h00aaa
`define FWS_UNLOCK_A2      20'h00555
`define FWS_UNLOCK_D1      8'haa
`define FWS_UNLOCK_D2      8'h55
`define FWS_CMD_PROG       8'ha0
`define FWS_CMD_SETUP      8'h80
`define FWS_CMD_CHIP       8'h10
`define FWS_CMD_SECT       8'h30
`define FWS_CMD_RESET      8'hf0
`define FWS_BIT_POLL       7
`define FWS_BIT_TOGGLE1    6
`define FWS_BIT_TIMEOUT    5
`define FWS_RESP_OKAY      2'h0
`define FWS_RESP_SLVERR    2'h2
`endif

// >>> src/fws_pkg.sv
// Types shared by the flash write-status controller.
// Assumes the constants header sits on the include path.
`include "fws_consts.svh"
package fws_pkg;
  typedef enum logic [1:0] {
    CYC_IDLE   = 2'h0,
    CYC_SETUP  = 2'h1,
    CYC_STROBE = 2'h3,
    CYC_HOLD   = 2'h2
  } fws_cyc_e;

  typedef enum logic [3:0] {
    S_IDLE     = 4'h0,
    S_CMD      = 4'h1,
    S_RD_A     = 4'h3,
    S_RD_B     = 4'h2,
    S_RD_FINAL = 4'h6,
    S_CHK_A    = 4'h7,
    S_CHK_B    = 4'h5,
    S_RST      = 4'h4,
    S_FIN      = 4'hc
  } fws_seq_e;

  typedef struct packed {
    logic                   ce_b;
    logic                   oe_b;
    logic                   we_b;
    logic [`FWS_ADDR_W-1:0] addr;
    logic [7:0]             dq_out;
    logic                   dq_oe;
  } fws_pins_s;

  typedef struct packed {
    logic [`FWS_ADDR_W-1:0] addr;
    logic [7:0]             data;
    logic                   last;
  } fws_step_s;
endpackage

// >>> src/fws_cycle.sv
// One flash bus cycle, read or write, with setup, strobe and recovery phases.
// Assumes the flash answers within the strobe time; pins are driven from flops.
`timescale 1ns/100ps
`include "fws_consts.svh"
module fws_cycle
  import fws_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_sync_b,
  input  wire logic                   clk_en,
  input  wire logic                   start,
  input  wire logic                   rd,
  input  wire logic [`FWS_ADDR_W-1:0] addr,
  input  wire logic [7:0]             wdata,
  input  wire logic [7:0]             dq_in,
  output fws_pins_s                   pins,
  output logic                        done,
  output logic [7:0]                  rdata
);
  fws_cyc_e              phase, next_phase;
  logic [`FWS_CNT_W-1:0] cnt, next_cnt;
  fws_pins_s             next_pins;
  logic                  next_done, rd_q, next_rd;
  logic [7:0]            next_rdata;

  always_comb begin
    next_phase = phase;
    next_cnt   = cnt;
    next_pins  = pins;
    next_done  = 1'b0;
    next_rdata = rdata;
    next_rd    = rd_q;
    case (phase)
      CYC_IDLE: if (start) begin
        next_pins.ce_b   = 1'b0;
        next_pins.addr   = addr;
        next_pins.dq_out = wdata;
        next_pins.dq_oe  = ~rd;
        next_rd          = rd;
        next_phase       = CYC_SETUP;
      end
      CYC_SETUP: begin
        next_pins.oe_b = ~rd_q;
        next_pins.we_b = rd_q;
        next_cnt       = `FWS_CNT_W'(`FWS_STROBE_CYC - 1);
        next_phase     = CYC_STROBE;
      end
      CYC_STROBE: if (cnt == '0) begin
        // Sample at the very end of the strobe so access time is met
        next_pins.oe_b = 1'b1;
        next_pins.we_b = 1'b1;
        next_rdata     = rd_q ? dq_in : rdata;
        next_cnt       = `FWS_CNT_W'(`FWS_RECOV_CYC - 1);
        next_phase     = CYC_HOLD;
      end else begin
        next_cnt = cnt - `FWS_CNT_W'(1);
      end
      CYC_HOLD: if (cnt == '0) begin
        // Data held past the write strobe edge, released with chip select
        next_pins.ce_b  = 1'b1;
        next_pins.dq_oe = 1'b0;
        next_done       = 1'b1;
        next_phase      = CYC_IDLE;
      end else begin
        next_cnt = cnt - `FWS_CNT_W'(1);
      end
      default: next_phase = CYC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      phase <= CYC_IDLE;
      cnt   <= '0;
      pins  <= '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, default: '0};
      done  <= 1'b0;
      rdata <= 8'h00;
      rd_q  <= 1'b0;
    end else if (clk_en) begin
      phase <= next_phase;
      cnt   <= next_cnt;
      pins  <= next_pins;
      done  <= next_done;
      rdata <= next_rdata;
      rd_q  <= next_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  chk_strobe_excl: assert property (@(posedge clk) disable iff (!rst_sync_b)
    !(!pins.oe_b && !pins.we_b))
    else $error("read and write strobes low together");
  chk_strobe_width: assert property (@(posedge clk) disable iff (!rst_sync_b)
    $fell(pins.we_b) |-> (!pins.we_b && pins.dq_oe && !pins.ce_b) [*8])
    else $error("write strobe pulse too short or data not driven");
endmodule

// >>> src/fws_ctrl.sv
// Host controller that runs program/erase command sequences on a parallel flash
// and follows them with toggle-bit status checking, reached over AXI4-Lite.
// Assumes flash pins are synchronous to clk and a pull-up on the ready/busy line.
// Operation
// - Poll only inside the targeted, unprotected sector; polls go to op_addr even when its sector is protected
// - Read again after completion for valid data
// - On timeout bit, recheck toggling before failing
// - After timeout failure, issue reset command
// - Two reads; unchanged toggle means complete
// - Toggling plus timeout: recheck, reset if still
// - Resumed monitoring restarts from first read pair
//
// Our own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "fws_consts.svh"
module fws_ctrl
  import fws_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   clk_en,
  input  wire logic                   rst_b,
  input  wire logic [4:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [4:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output fws_pins_s                   flash_pins,
  input  wire logic [7:0]             dq_in,
  input  wire logic                   ready_busy_out
);
  ////////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_pipe;
  logic       rst_sync_b;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_sync_b = rst_pipe[1];

  // {valid, word index}; only the first four aligned words exist
  function automatic logic [2:0] reg_sel(input logic [4:0] a);
    reg_sel = {a[4] == 1'b0 && a[1:0] == 2'h0, a[3:2]};
  endfunction

  function automatic fws_step_s cmd_step(input logic [1:0] op, input logic [2:0] step,
                                         input logic [`FWS_ADDR_W-1:0] a, input logic [7:0] d);
    fws_step_s s;
    s = '{`FWS_UNLOCK_A1, `FWS_UNLOCK_D1, 1'b0};
    if (op == `FWS_OP_RESET) begin
      s = '{`FWS_UNLOCK_A1, `FWS_CMD_RESET, 1'b1};
    end else begin
      case (step)
        3'h0: s = '{`FWS_UNLOCK_A1, `FWS_UNLOCK_D1, 1'b0};
        3'h1: s = '{`FWS_UNLOCK_A2, `FWS_UNLOCK_D2, 1'b0};
        3'h2: s = '{`FWS_UNLOCK_A1, (op == `FWS_OP_PROG) ? `FWS_CMD_PROG : `FWS_CMD_SETUP, 1'b0};
        3'h3: if (op == `FWS_OP_PROG) begin
          s = '{a, d, 1'b1};
        end else begin
          s = '{`FWS_UNLOCK_A1, `FWS_UNLOCK_D1, 1'b0};
        end
        3'h4: s = '{`FWS_UNLOCK_A2, `FWS_UNLOCK_D2, 1'b0};
        default: if (op == `FWS_OP_CHIP) begin
          s = '{`FWS_UNLOCK_A1, `FWS_CMD_CHIP, 1'b1};
        end else begin
          s = '{a, `FWS_CMD_SECT, 1'b1};
        end
      endcase
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  logic                   aw_held, next_aw_held, w_held, next_w_held;
  logic [4:0]             wr_addr, next_wr_addr;
  logic [31:0]            wr_data, next_wr_data;
  logic [3:0]             wr_strb, next_wr_strb;
  logic                   next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]             next_bresp, next_rresp;
  logic [31:0]            next_rdata;
  logic [1:0]             op, next_op;
  logic [`FWS_ADDR_W-1:0] op_addr, next_op_addr;
  logic [7:0]             op_data, next_op_data;
  logic                   go, next_go;
  logic                   busy, done, fail, verify_err;
  logic [7:0]             result, last_status;

  always_comb begin
    logic [2:0]  sel;
    logic [2:0]  rsel;
    logic [31:0] merged;
    logic [31:0] stat;
    sel    = reg_sel(aw_held ? wr_addr : 5'h00);
    // Only the valid flag decides the response, not the word index
    rsel   = reg_sel(s_axi_araddr);
    merged = 32'h0;
    stat   = 32'h0;
    stat[`FWS_ST_BUSY]   = busy;
    stat[`FWS_ST_DONE]   = done;
    stat[`FWS_ST_FAIL]   = fail;
    stat[`FWS_ST_VERIFY] = verify_err;
    stat[`FWS_ST_RDY]    = ready_busy_out;
    stat[`FWS_ST_RESULT_LSB +: 8] = result;
    stat[`FWS_ST_LAST_LSB +: 8]   = last_status;
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    next_op      = op;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_go      = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_wr_data = s_axi_wdata;
      next_wr_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = sel[2] ? `FWS_RESP_OKAY : `FWS_RESP_SLVERR;
      merged = (wr_addr == `FWS_REG_ADDR) ? 32'(op_addr) : 32'(op_data);
      for (int i = 0; i < 4; i++) begin
        if (wr_strb[i]) begin
          merged[8*i +: 8] = wr_data[8*i +: 8];
        end
      end
      // Parameters are frozen while a sequence runs
      if (sel[2] && !busy) begin
        case (wr_addr)
          `FWS_REG_CTRL: if (wr_strb[0]) begin
            next_op = wr_data[`FWS_CTRL_OP_LSB +: 2];
            next_go = wr_data[`FWS_CTRL_GO];
          end
          `FWS_REG_ADDR: next_op_addr = merged[`FWS_ADDR_W-1:0];
          `FWS_REG_DATA: next_op_data = merged[7:0];
          default: next_go = 1'b0;
        endcase
      end
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = rsel[2] ? `FWS_RESP_OKAY : `FWS_RESP_SLVERR;
      case (s_axi_araddr)
        `FWS_REG_CTRL:   next_rdata = 32'(op) << `FWS_CTRL_OP_LSB;
        `FWS_REG_ADDR:   next_rdata = 32'(op_addr);
        `FWS_REG_DATA:   next_rdata = 32'(op_data);
        `FWS_REG_STATUS: next_rdata = stat;
        default:         next_rdata = 32'h0;
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_addr       <= 5'h00;
      wr_data       <= 32'h0;
      wr_strb       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'h0;
      s_axi_rdata   <= 32'h0;
      op            <= `FWS_OP_PROG;
      op_addr       <= '0;
      op_data       <= 8'h00;
      go            <= 1'b0;
    end else if (clk_en) begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      wr_addr       <= next_wr_addr;
      wr_data       <= next_wr_data;
      wr_strb       <= next_wr_strb;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rresp   <= next_rresp;
      s_axi_rdata   <= next_rdata;
      op            <= next_op;
      op_addr       <= next_op_addr;
      op_data       <= next_op_data;
      go            <= next_go;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  fws_seq_e               state, next_state;
  logic [2:0]             step, next_step;
  logic                   issued, next_issued;
  logic [7:0]             first_byte, next_first;
  logic                   next_busy, next_done, next_fail, next_verify;
  logic [7:0]             next_result, next_last;
  logic                   cyc_start, cyc_rd, cyc_done, toggles;
  logic [7:0]             cyc_rdata;
  fws_step_s              cur;

  assign cur     = cmd_step((state == S_RST) ? `FWS_OP_RESET : op, step, op_addr, op_data);
  assign cyc_rd  = state != S_CMD && state != S_RST;
  assign toggles = cyc_rdata[`FWS_BIT_TOGGLE1] != first_byte[`FWS_BIT_TOGGLE1];

  always_comb begin
    next_state  = state;
    next_step   = step;
    next_issued = issued;
    next_first  = first_byte;
    next_busy   = busy;
    next_done   = done;
    next_fail   = fail;
    next_verify = verify_err;
    next_result = result;
    next_last   = last_status;
    cyc_start   = 1'b0;
    if (state == S_IDLE) begin
      if (go) begin
        next_state  = S_CMD;
        next_step   = 3'h0;
        next_busy   = 1'b1;
        next_done   = 1'b0;
        next_fail   = 1'b0;
        next_verify = 1'b0;
      end
    end else if (state == S_FIN) begin
      next_busy  = 1'b0;
      next_done  = 1'b1;
      next_state = S_IDLE;
    end else if (!issued) begin
      cyc_start   = 1'b1;
      next_issued = 1'b1;
    end else if (cyc_done) begin
      next_issued = 1'b0;
      case (state)
        S_CMD: if (cur.last) begin
          next_state = (op == `FWS_OP_RESET) ? S_FIN : S_RD_A;
        end else begin
          next_step = step + 3'h1;
        end
        S_RD_A: begin
          next_first = cyc_rdata;
          next_state = S_RD_B;
        end
        S_RD_B: begin
          next_last = cyc_rdata;
          if (!toggles) next_state = S_RD_FINAL;
          else if (cyc_rdata[`FWS_BIT_TIMEOUT]) next_state = S_CHK_A;
          else next_state = S_RD_A;
        end
        S_CHK_A: begin
          next_first = cyc_rdata;
          next_state = S_CHK_B;
        end
        S_CHK_B: begin
          next_last  = cyc_rdata;
          next_fail  = toggles;
          next_state = toggles ? S_RST : S_RD_FINAL;
        end
        S_RD_FINAL: begin
          // Fresh read after completion; poll bit compared against target
          next_result = cyc_rdata;
          next_verify = cyc_rdata[`FWS_BIT_POLL] !=
                        ((op == `FWS_OP_PROG) ? op_data[`FWS_BIT_POLL] : 1'b1);
          next_state  = S_FIN;
        end
        default: next_state = S_FIN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state       <= S_IDLE;
      step        <= 3'h0;
      issued      <= 1'b0;
      first_byte  <= 8'h00;
      busy        <= 1'b0;
      done        <= 1'b0;
      fail        <= 1'b0;
      verify_err  <= 1'b0;
      result      <= 8'h00;
      last_status <= 8'h00;
    end else if (clk_en) begin
      state       <= next_state;
      step        <= next_step;
      issued      <= next_issued;
      first_byte  <= next_first;
      busy        <= next_busy;
      done        <= next_done;
      fail        <= next_fail;
      verify_err  <= next_verify;
      result      <= next_result;
      last_status <= next_last;
    end
  end

  // Status reads go to the operation's own address, never elsewhere
  fws_cycle u_cycle (
    .clk        (clk),
    .rst_sync_b (rst_sync_b),
    .clk_en     (clk_en),
    .start      (cyc_start),
    .rd         (cyc_rd),
    .addr       (cyc_rd ? op_addr : cur.addr),
    .wdata      (cur.data),
    .dq_in      (dq_in),
    .pins       (flash_pins),
    .done       (cyc_done),
    .rdata      (cyc_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  chk_stable_final: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (clk_en && state == S_RD_B && cyc_done && !toggles) |=> state == S_RD_FINAL)
    else $error("unchanged toggle bit did not end polling");
  chk_extra_read: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (clk_en && state == S_RD_FINAL && cyc_done) |=> (state == S_FIN && result == $past(cyc_rdata)))
    else $error("completion data not taken from the extra read");
  chk_err_recheck: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (clk_en && state == S_RD_B && cyc_done && toggles && cyc_rdata[5]) |=> state == S_CHK_A ##1 !fail)
    else $error("timeout bit did not lead to a recheck");
  chk_restart_pair: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (clk_en && state == S_RD_B && cyc_done && toggles && !cyc_rdata[5]) |=> state == S_RD_A)
    else $error("monitoring did not restart from the first read");
  chk_fail_reset: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (clk_en && state == S_CHK_B && cyc_done && toggles) |=> (fail && state == S_RST))
    else $error("persistent toggling not treated as failure");
  chk_reset_cmd: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (clk_en && state == S_RST && cyc_start) |-> (!cyc_rd && cur.data == `FWS_CMD_RESET) ##1 !flash_pins.ce_b)
    else $error("failure not followed by the reset command");
  chk_poll_addr: assert property (@(posedge clk) disable iff (!rst_sync_b)
    (clk_en && cyc_start && cyc_rd) |=> (flash_pins.addr == op_addr && !flash_pins.dq_oe))
    else $error("status read at an address other than the target");
endmodule

// >>> verification/fws_flash_model.sv
// Behavioural byte-wide flash: command decoder, busy timer and status bits.
// Assumes pins from the controller; the bench resolves the data wire.
`timescale 1ns/100ps
module fws_flash_model
  import fws_pkg::*;
// Locked-sector busy times scaled far down to keep runs short
#(parameter int       BUSY_CYC       = 40,
  parameter int       PROT_PROG_CYC  = 50,
  parameter int       PROT_ERASE_CYC = 500,
  parameter bit [3:0] PROT_SECT      = 4'hf)
(
  input  wire logic      clk,
  input  wire fws_pins_s pins,
  output logic [7:0]     fl_dq,
  output logic           fl_oe,
  output logic           rb_low
);
  logic [7:0] mem [256];
  logic [7:0] pd, a, mode;
  logic [2:0] n = 0;
  logic       busy = 0, er = 0, err = 0, halt = 0, tmr = 0, tog = 0, chip = 0, prot = 0;
  int         cnt;
  // One pre-filled byte in the locked sector shows that it is left alone
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    mem[{PROT_SECT, 4'h3}] = 8'h3c;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Commands latch on the strobe's rising edge
  always @(posedge pins.we_b) if (!pins.ce_b) begin
    if (busy) begin
      if (err && pins.dq_out == 8'hf0) begin
        busy = 0;
        err = 0;
      end
    end else if (pins.dq_out == 8'hf0) n = 0;
    else begin
      n = n + 3'h1;
      if (n == 3'h3) mode = pins.dq_out;
      if ((n == 3'h4 && mode == 8'ha0) || (n == 3'h6 && mode == 8'h80)) begin
        er = mode == 8'h80;
        chip = pins.dq_out == 8'h10;
        tmr = er && !chip;
        a = pins.addr[7:0];
        pd = er ? 8'hff : pins.dq_out;
        prot = !chip && a[7:4] == PROT_SECT;
        // Erase only sets bits, so only a program can halt
        halt = !er && !prot && |(pd & ~mem[a]);
        busy = 1;
        cnt = prot ? (er ? PROT_ERASE_CYC : PROT_PROG_CYC) : BUSY_CYC;
        n = 0;
      end
    end
  end
  // Updates land after the controller has sampled this edge
  always @(posedge clk) if (busy && !err) begin
    if (cnt > 0) cnt <= cnt - 1;
    else if (halt) err <= 1;
    else begin
      busy <= 0;
      tmr <= 0;
      if (!er && !prot) mem[a] <= pd;
      else if (er) foreach (mem[i]) if ((chip || i[7:4] == a[7:4]) && i[7:4] != PROT_SECT) mem[i] <= 8'hff;
    end
  end
  always @(posedge pins.oe_b) if (!pins.ce_b && busy) tog = ~tog;
  ////////////////////////////////////////////////////////////////////////////
  // Status switches to data in one step, so no mid-read flip
  assign fl_oe = !pins.ce_b && !pins.oe_b;
  assign fl_dq = busy ? {er ? 1'b0 : ~pd[7], tog, err, 1'b0, tmr,
                 er && (chip || pins.addr[7:4] == a[7:4]) && tog, 2'h0} : mem[pins.addr[7:0]];
  assign rb_low = busy;
endmodule

// >>> verification/tb.sv
// Self-checking bench: AXI4-Lite tasks run each operation and check STATUS.
// Assumes the flash model above; data wire resolved here.
`timescale 1ns/100ps
module tb;
  import fws_pkg::*;
  logic        clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, rb_low, fl_oe, saw_low;
  logic [4:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, st;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  dq, fl_dq, dq_last = 0;
  fws_pins_s   pins;
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  logic [49:0] tbl [9];
  always #2 clk = ~clk;
  fws_ctrl dut (.clk(clk), .clk_en(1'b1), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flash_pins(pins), .dq_in(dq),
    .ready_busy_out(!rb_low));
  fws_flash_model flash (.clk(clk), .pins(pins), .fl_dq(fl_dq), .fl_oe(fl_oe), .rb_low(rb_low));
  // Undriven wire shows a changing value, never the last one
  assign dq = pins.dq_oe ? pins.dq_out : fl_oe ? fl_dq : ~dq_last;
  always @(posedge clk) dq_last <= dq;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (rvalid !== 1'b1);
    d = rdata;
    resp = rresp;
    rready <= 0;
  endtask
  // Row: op, address, data, expected STATUS[15:0], mask
  task automatic run_op(input logic [49:0] t);
    wr(5'h04, {24'h0, t[47:40]}, r);
    wr(5'h08, {24'h0, t[39:32]}, r);
    wr(5'h00, {29'h0, t[49:48], 1'b1}, r);
    saw_low = 0;
    do begin
      rd(5'h0c, st, r);
      if (st[4] === 1'b0) saw_low = 1;
    end while (st[0] !== 1'b0 || st[1] !== 1'b1);
    check({16'h0, st[15:0] & t[15:0]}, {16'h0, t[31:16]});
    check({31'h0, saw_low}, {31'h0, t[49:48] != 2'h3});
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict;
    end
  end
  initial begin
    tbl = '{{2'h0, 8'h12, 8'h5a, 16'h5a12, 16'hffff}, {2'h0, 8'h12, 8'hff, 16'h0016, 16'h00f7},
            {2'h0, 8'h13, 8'h00, 16'h0012, 16'hffff}, {2'h2, 8'h12, 8'h00, 16'hff12, 16'hffff},
            {2'h0, 8'h12, 8'ha5, 16'ha512, 16'hffff}, {2'h1, 8'h00, 8'h00, 16'hff12, 16'hffff},
            {2'h0, 8'hf3, 8'h00, 16'h3c12, 16'hffff}, {2'h2, 8'hf3, 8'h00, 16'h3c1a, 16'hffff},
            {2'h3, 8'h00, 8'h00, 16'h0012, 16'h00f7}};
    repeat (4) @(posedge clk);
    rst_b <= 1;
    repeat (4) @(posedge clk);
    rd(5'h0c, st, r);
    check({27'h0, st[4:0]}, 32'h10);
    rd(5'h10, st, r);
    check({30'h0, r}, 32'h2);
    wr(5'h14, 32'h1, r);
    check({30'h0, r}, 32'h2);
    foreach (tbl[i]) run_op(tbl[i]);
    give_verdict;
  end
endmodule
